/* rtl/clock_prescaler.sv */
`timescale 1ns/1ps
module clock_prescaler
(
	input  wire logic       clk_sys,
	input  wire logic       rst,
	input  wire logic [1:0] scale,
	input  wire logic       ext_rise,
	output logic            tick
);
	logic [5:0] div_ff;
	logic [2:0] ext_ff;
	logic [5:0] last;
	logic       tick_ff;

	always_comb
	begin
		case (scale)
			timer_pkg::SCALE_DIV12: last = timer_pkg::DIV12_LAST;
			timer_pkg::SCALE_DIV4:  last = timer_pkg::DIV4_LAST;
			timer_pkg::SCALE_DIV48: last = timer_pkg::DIV48_LAST;
			default:                last = timer_pkg::DIV48_LAST;
		endcase
	end

	// ----------------------------------------------------------------
	// Divider for system clock and external clock
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			div_ff  <= 6'h00;
			ext_ff  <= 3'h0;
			tick_ff <= 1'b0;
		end
		else if (scale == timer_pkg::SCALE_EXT8)
		begin
			div_ff  <= 6'h00;
			if (ext_rise)
				ext_ff <= ext_ff + 3'h1;
			tick_ff <= ext_rise && (ext_ff == timer_pkg::EXT8_LAST);
		end
		else
		begin
			ext_ff  <= 3'h0;
			div_ff  <= (div_ff >= last) ? 6'h00 : div_ff + 6'h01;
			tick_ff <= (div_ff >= last);
		end
	end

	assign tick = tick_ff;
endmodule

/* rtl/dual_legacy_counter_timer.sv */
// Functional notes
// - 13-bit mode counts high byte plus low bits 4..0; low bits 7..5 untouched.
// - 13-bit wrap 1FFF to 0 sets overflow flag; interrupt if enabled.
// - Counter-select 1 increments on each falling edge of event pin.
// - Counter-select 0 counts system clock or prescaled clock per clock-select.
// - Event pin sampled by system clock; rates up to quarter clock.
// - Count only with run bit and gate off or gate input active.
// - Run bit never clears count; software loads start value first.
// - Timer B mirrors timer A in modes 0, 1, 2 with own bits.
// - 16-bit mode uses all sixteen bits as the count.
// - Reload mode: low byte wraps, sets flag, reloads from unchanged high byte.
// - Split mode: A low byte is 8-bit timer with A control bits.
// - Split mode: A high byte counts internal clock, runs on B run, sets B flag.
// - While A split, B counts internal only, no flag, overflow still output.
// - B mode 3 stops B; while A split B runs per mode field.
// - Each timer has own mode field; split mode only for timer A.
// - Interrupt request only when flag set and its enable bit is 1.
// - Scale 00 div12, 01 div4, 10 div48, 11 external clock div8.
// - Mode 00 13-bit, 01 16-bit, 10 reload, 11 split or B inactive.
// - Flags cleared by software or automatically on interrupt vectoring.
`timescale 1ns/1ps
module dual_legacy_counter_timer
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        event_pin_a,
	input  wire logic        event_pin_b,
	input  wire logic        gate_input_a,
	input  wire logic        gate_input_b,
	input  wire logic        ext_clk,
	input  wire logic        irq_ack_a,
	input  wire logic        irq_ack_b,
	output logic             irq_req_a,
	output logic             irq_req_b,
	output logic             overflow_b_tick
);
	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0]  ctrl_ff;
	logic [7:0]  mode_ff;
	logic [7:0]  clksel_ff;
	logic [7:0]  a_low_ff;
	logic [7:0]  a_high_ff;
	logic [7:0]  b_low_ff;
	logic [7:0]  b_high_ff;
	logic [1:0]  extcfg_ff;
	logic [1:0]  irqen_ff;
	logic        awready_ff;
	logic        wready_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        arready_ff;
	logic        rvalid_ff;
	logic [1:0]  rresp_ff;
	logic [7:0]  rdata_ff;
	logic        irq_a_ff;
	logic        irq_b_ff;
	logic        ovf_b_ff;

	logic        ev_fall_a;
	logic        ev_fall_b;
	logic        ext_rise;
	logic        pre_tick;
	logic        wr_go;
	logic [5:0]  wr_ofs;
	logic [7:0]  wr_byte;
	logic [5:0]  rd_ofs;
	logic [1:0]  mode_a;
	logic [1:0]  mode_b;
	logic        split;
	logic        en_a;
	logic        en_b;
	logic        en_ah;
	logic        tick_a;
	logic        tick_b;
	logic        tick_ah;
	logic [16:0] step_a;
	logic [16:0] step_b;
	logic [8:0]  step_ah;
	logic        set_flag_a;
	logic        set_flag_b;
	logic        ovf_b;

	// ----------------------------------------------------------------
	// Count step: returns {overflow, high, low}
	// ----------------------------------------------------------------
	function automatic logic [16:0] count_step(input logic [1:0] m, input logic [7:0] lo,
		input logic [7:0] hi);
		logic [12:0] c13;
		logic [15:0] c16;
		c13 = {hi, lo[4:0]};
		c16 = {hi, lo};
		case (m)
			timer_pkg::MODE_13BIT:
			begin
				c13 = c13 + 13'h0001;
				count_step = {({hi, lo[4:0]} == timer_pkg::MAX13), c13[12:5], lo[7:5],
					c13[4:0]};
			end
			timer_pkg::MODE_16BIT:
			begin
				c16 = c16 + 16'h0001;
				count_step = {({hi, lo} == timer_pkg::MAX16), c16};
			end
			timer_pkg::MODE_RELOAD:
				count_step = (lo == timer_pkg::MAX8) ? {1'b1, hi, hi}
					: {1'b0, hi, lo + 8'h01};
			default:
				count_step = {(lo == timer_pkg::MAX8), hi, lo + 8'h01};
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Pin sampling and prescaler
	// ----------------------------------------------------------------
	edge_sampler u_ev_a
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.pin     (event_pin_a),
		.fall    (ev_fall_a),
		.rise    ()
	);

	edge_sampler u_ev_b
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.pin     (event_pin_b),
		.fall    (ev_fall_b),
		.rise    ()
	);

	edge_sampler u_ext
	(
		.clk_sys (clk_sys),
		.rst     (rst),
		.pin     (ext_clk),
		.fall    (),
		.rise    (ext_rise)
	);

	clock_prescaler u_pre
	(
		.clk_sys  (clk_sys),
		.rst      (rst),
		.scale    (clksel_ff[timer_pkg::POS_SCALE +: 2]),
		.ext_rise (ext_rise),
		.tick     (pre_tick)
	);

	// ----------------------------------------------------------------
	// Count enables and sources
	// ----------------------------------------------------------------
	assign mode_a = mode_ff[timer_pkg::POS_MODE_A +: 2];
	assign mode_b = mode_ff[timer_pkg::POS_MODE_B +: 2];
	assign split  = (mode_a == timer_pkg::MODE_SPLIT);

	assign en_a = ctrl_ff[timer_pkg::BIT_RUN_A] & (~mode_ff[timer_pkg::BIT_GATE_A]
		| (gate_input_a == extcfg_ff[timer_pkg::BIT_POL_A]));
	assign en_b = (mode_b != timer_pkg::MODE_SPLIT) & (split
		| (ctrl_ff[timer_pkg::BIT_RUN_B] & (~mode_ff[timer_pkg::BIT_GATE_B]
		| (gate_input_b == extcfg_ff[timer_pkg::BIT_POL_B]))));
	assign en_ah = split & ctrl_ff[timer_pkg::BIT_RUN_B];

	assign tick_a = mode_ff[timer_pkg::BIT_CSEL_A] ? ev_fall_a
		: (clksel_ff[timer_pkg::BIT_SYSSEL_A] | pre_tick);
	assign tick_b = (mode_ff[timer_pkg::BIT_CSEL_B] & ~split) ? ev_fall_b
		: (clksel_ff[timer_pkg::BIT_SYSSEL_B] | pre_tick);
	assign tick_ah = clksel_ff[timer_pkg::BIT_SYSSEL_A] | pre_tick;

	assign step_a  = count_step(mode_a, a_low_ff, a_high_ff);
	assign step_b  = count_step(mode_b, b_low_ff, b_high_ff);
	assign step_ah = {(a_high_ff == timer_pkg::MAX8), a_high_ff + 8'h01};

	assign ovf_b      = en_b & tick_b & step_b[16];
	assign set_flag_a = en_a & tick_a & step_a[16];
	assign set_flag_b = split ? (en_ah & tick_ah & step_ah[8]) : ovf_b;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	assign wr_go   = s_axi_awvalid & s_axi_wvalid & ~awready_ff & ~bvalid_ff;
	// Refused addresses map to an offset that matches no register
	assign wr_ofs  = known(s_axi_awaddr) ? s_axi_awaddr[5:0] : 6'h3F;
	assign wr_byte = s_axi_wdata[7:0];
	assign rd_ofs  = known(s_axi_araddr) ? s_axi_araddr[5:0] : 6'h3F;

	function automatic logic known(input logic [31:0] addr);
		known = (addr[31:6] == 26'h0000000) && (addr[1:0] == 2'b00)
			&& (addr[5:0] <= timer_pkg::OFS_IRQEN);
	endfunction

	function automatic logic wr_hit(input logic go, input logic [3:0] strb,
		input logic [5:0] ofs, input logic [5:0] target);
		wr_hit = go & strb[0] & (ofs == target);
	endfunction

	// ----------------------------------------------------------------
	// Write channel
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			awready_ff <= 1'b0;
			wready_ff  <= 1'b0;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= timer_pkg::RESP_OKAY;
		end
		else
		begin
			awready_ff <= wr_go;
			wready_ff  <= wr_go;
			if (wr_go)
			begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= known(s_axi_awaddr) ? timer_pkg::RESP_OKAY
					: timer_pkg::RESP_SLVERR;
			end
			else if (s_axi_bready)
				bvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Read channel
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b0;
			rresp_ff   <= timer_pkg::RESP_OKAY;
			rdata_ff   <= timer_pkg::RST_BYTE;
		end
		else
		begin
			arready_ff <= s_axi_arvalid & ~arready_ff & ~rvalid_ff;
			if (s_axi_arvalid & ~arready_ff & ~rvalid_ff)
			begin
				rvalid_ff <= 1'b1;
				rresp_ff  <= known(s_axi_araddr) ? timer_pkg::RESP_OKAY
					: timer_pkg::RESP_SLVERR;
				case (rd_ofs)
					timer_pkg::OFS_CONTROL: rdata_ff <= ctrl_ff;
					timer_pkg::OFS_MODE:    rdata_ff <= mode_ff;
					timer_pkg::OFS_CLKSEL:  rdata_ff <= clksel_ff;
					timer_pkg::OFS_A_LOW:   rdata_ff <= a_low_ff;
					timer_pkg::OFS_A_HIGH:  rdata_ff <= a_high_ff;
					timer_pkg::OFS_B_LOW:   rdata_ff <= b_low_ff;
					timer_pkg::OFS_B_HIGH:  rdata_ff <= b_high_ff;
					timer_pkg::OFS_EXTCFG:  rdata_ff <= {6'h00, extcfg_ff};
					timer_pkg::OFS_IRQEN:   rdata_ff <= {6'h00, irqen_ff};
					default:                rdata_ff <= timer_pkg::RST_BYTE;
				endcase
			end
			else if (s_axi_rready)
				rvalid_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			mode_ff   <= timer_pkg::RST_BYTE;
			clksel_ff <= timer_pkg::RST_BYTE;
			extcfg_ff <= 2'b00;
			irqen_ff  <= 2'b00;
		end
		else
		begin
			if (wr_hit(wr_go, s_axi_wstrb, wr_ofs, timer_pkg::OFS_MODE))
				mode_ff <= wr_byte;
			if (wr_hit(wr_go, s_axi_wstrb, wr_ofs, timer_pkg::OFS_CLKSEL))
				clksel_ff <= {4'h0, wr_byte[3:0]};
			if (wr_hit(wr_go, s_axi_wstrb, wr_ofs, timer_pkg::OFS_EXTCFG))
				extcfg_ff <= wr_byte[1:0];
			if (wr_hit(wr_go, s_axi_wstrb, wr_ofs, timer_pkg::OFS_IRQEN))
				irqen_ff <= wr_byte[1:0];
		end
	end

	// ----------------------------------------------------------------
	// Control register: run bits and sticky flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			ctrl_ff <= timer_pkg::RST_BYTE;
		else
		begin
			if (wr_hit(wr_go, s_axi_wstrb, wr_ofs, timer_pkg::OFS_CONTROL))
				ctrl_ff <= {wr_byte[7:4], 4'h0};
			else
			begin
				if (irq_ack_a)
					ctrl_ff[timer_pkg::BIT_FLAG_A] <= 1'b0;
				if (irq_ack_b)
					ctrl_ff[timer_pkg::BIT_FLAG_B] <= 1'b0;
			end
			if (set_flag_a)
				ctrl_ff[timer_pkg::BIT_FLAG_A] <= 1'b1;
			if (set_flag_b)
				ctrl_ff[timer_pkg::BIT_FLAG_B] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Timer A bytes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			a_low_ff  <= timer_pkg::RST_BYTE;
			a_high_ff <= timer_pkg::RST_BYTE;
		end
		else
		begin
			if (wr_hit(wr_go, s_axi_wstrb, wr_ofs, timer_pkg::OFS_A_LOW))
				a_low_ff <= wr_byte;
			else if (en_a & tick_a)
				a_low_ff <= step_a[7:0];
			if (wr_hit(wr_go, s_axi_wstrb, wr_ofs, timer_pkg::OFS_A_HIGH))
				a_high_ff <= wr_byte;
			else if (split)
			begin
				if (en_ah & tick_ah)
					a_high_ff <= step_ah[7:0];
			end
			else if (en_a & tick_a)
				a_high_ff <= step_a[15:8];
		end
	end

	// ----------------------------------------------------------------
	// Timer B bytes
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			b_low_ff  <= timer_pkg::RST_BYTE;
			b_high_ff <= timer_pkg::RST_BYTE;
		end
		else
		begin
			if (wr_hit(wr_go, s_axi_wstrb, wr_ofs, timer_pkg::OFS_B_LOW))
				b_low_ff <= wr_byte;
			else if (en_b & tick_b)
				b_low_ff <= step_b[7:0];
			if (wr_hit(wr_go, s_axi_wstrb, wr_ofs, timer_pkg::OFS_B_HIGH))
				b_high_ff <= wr_byte;
			else if (en_b & tick_b)
				b_high_ff <= step_b[15:8];
		end
	end

	// ----------------------------------------------------------------
	// Interrupt requests and overflow output
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			irq_a_ff <= 1'b0;
			irq_b_ff <= 1'b0;
			ovf_b_ff <= 1'b0;
		end
		else
		begin
			irq_a_ff <= ctrl_ff[timer_pkg::BIT_FLAG_A] & irqen_ff[timer_pkg::BIT_IEN_A];
			irq_b_ff <= ctrl_ff[timer_pkg::BIT_FLAG_B] & irqen_ff[timer_pkg::BIT_IEN_B];
			ovf_b_ff <= ovf_b;
		end
	end

	assign s_axi_awready   = awready_ff;
	assign s_axi_wready    = wready_ff;
	assign s_axi_bvalid    = bvalid_ff;
	assign s_axi_bresp     = bresp_ff;
	assign s_axi_arready   = arready_ff;
	assign s_axi_rvalid    = rvalid_ff;
	assign s_axi_rresp     = rresp_ff;
	assign s_axi_rdata     = {24'h000000, rdata_ff};
	assign irq_req_a       = irq_a_ff;
	assign irq_req_b       = irq_b_ff;
	assign overflow_b_tick = ovf_b_ff;
endmodule

/* rtl/edge_sampler.sv */
`timescale 1ns/1ps
module edge_sampler
(
	input  wire logic clk_sys,
	input  wire logic rst,
	input  wire logic pin,
	output logic      fall,
	output logic      rise
);
	logic sample_ff;
	logic prev_ff;

	// ----------------------------------------------------------------
	// Pin sampled each system clock, edges from two samples
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sample_ff <= 1'b1;
			prev_ff   <= 1'b1;
		end
		else
		begin
			sample_ff <= pin;
			prev_ff   <= sample_ff;
		end
	end

	assign fall = prev_ff & ~sample_ff;
	assign rise = ~prev_ff & sample_ff;
endmodule

/* rtl/timer_pkg.sv */
package timer_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] OFS_CONTROL  = 6'h00;
	localparam logic [5:0] OFS_MODE     = 6'h04;
	localparam logic [5:0] OFS_CLKSEL   = 6'h08;
	localparam logic [5:0] OFS_A_LOW    = 6'h0C;
	localparam logic [5:0] OFS_A_HIGH   = 6'h10;
	localparam logic [5:0] OFS_B_LOW    = 6'h14;
	localparam logic [5:0] OFS_B_HIGH   = 6'h18;
	localparam logic [5:0] OFS_EXTCFG   = 6'h1C;
	localparam logic [5:0] OFS_IRQEN    = 6'h20;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_FLAG_B   = 7;
	localparam int BIT_RUN_B    = 6;
	localparam int BIT_FLAG_A   = 5;
	localparam int BIT_RUN_A    = 4;
	localparam int BIT_GATE_B   = 7;
	localparam int BIT_CSEL_B   = 6;
	localparam int POS_MODE_B   = 4;
	localparam int BIT_GATE_A   = 3;
	localparam int BIT_CSEL_A   = 2;
	localparam int POS_MODE_A   = 0;
	localparam int BIT_SYSSEL_B = 3;
	localparam int BIT_SYSSEL_A = 2;
	localparam int POS_SCALE    = 0;
	localparam int BIT_POL_A    = 0;
	localparam int BIT_POL_B    = 1;
	localparam int BIT_IEN_A    = 0;
	localparam int BIT_IEN_B    = 1;

	// ----------------------------------------------------------------
	// Reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [7:0]  RST_BYTE   = 8'h00;
	localparam logic [12:0] MAX13      = 13'h1FFF;
	localparam logic [15:0] MAX16      = 16'hFFFF;
	localparam logic [7:0]  MAX8       = 8'hFF;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	typedef enum logic [1:0]
	{
		MODE_13BIT  = 2'b00,
		MODE_16BIT  = 2'b01,
		MODE_RELOAD = 2'b10,
		MODE_SPLIT  = 2'b11
	} mode_t;

	typedef enum logic [1:0]
	{
		SCALE_DIV12 = 2'b00,
		SCALE_DIV4  = 2'b01,
		SCALE_DIV48 = 2'b10,
		SCALE_EXT8  = 2'b11
	} scale_t;

	// ----------------------------------------------------------------
	// Prescaler divisors (terminal counts)
	// ----------------------------------------------------------------
	localparam logic [5:0] DIV12_LAST = 6'h0B;
	localparam logic [5:0] DIV4_LAST  = 6'h03;
	localparam logic [5:0] DIV48_LAST = 6'h2F;
	localparam logic [2:0] EXT8_LAST  = 3'h7;

endpackage

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	logic        clk_sys, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, irq_ack, irq_req, last_b, rd_resp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, overflow_b_tick;
	logic        event_pin_a, event_pin_b, gate_input_a, gate_input_b, ext_clk;
	logic [7:0]  rd_byte;
	logic [31:0] r;
	int          err_total, check_count, seed, k, t0, cnt, exp_cnt, cyc = 0, tick_n = 0;
	int          div[5] = '{12, 4, 48, 40, 1};
	dual_legacy_counter_timer i_dut (.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.event_pin_a, .event_pin_b, .gate_input_a, .gate_input_b, .ext_clk,
		.irq_ack_a(irq_ack[0]), .irq_ack_b(irq_ack[1]), .irq_req_a(irq_req[0]),
		.irq_req_b(irq_req[1]), .overflow_b_tick);
	timer_far_side i_far (.clk_sys, .event_pin_a, .event_pin_b, .gate_input_a,
		.gate_input_b, .ext_clk);
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys)
	begin
		cyc <= cyc + 1;
		if (overflow_b_tick === 1'b1)
			tick_n <= tick_n + 1;
	end
	task automatic complete_run();
		if (err_total == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wait_hi(input logic rd_side);
		do
			@(posedge clk_sys);
		while ((rd_side ? s_axi_arready & s_axi_rvalid : s_axi_awready & s_axi_bvalid) !== 1'b1);
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		s_axi_awaddr <= {26'h0, a};
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		wait_hi(1'b0);
		last_b = s_axi_bresp;
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
	endtask
	task automatic rd(input logic [5:0] a);
		@(posedge clk_sys);
		s_axi_araddr <= {26'h0, a};
		s_axi_arvalid <= 1'b1;
		wait_hi(1'b1);
		rd_byte = s_axi_rdata[7:0];
		rd_resp = s_axi_rresp;
		s_axi_arvalid <= 1'b0;
	endtask
	// Expected {flag, high, low} after n counts
	function automatic logic [16:0] model(input logic [1:0] m, input logic [7:0] h,
		input logic [7:0] l, input int n);
		logic [16:0] v;
		v = {1'b0, h, l};
		repeat (n)
			case (m)
				2'd0:
				begin
					v[16] = v[16] | ({v[15:8], v[4:0]} == 13'h1FFF);
					{v[15:8], v[4:0]} = {v[15:8], v[4:0]} + 13'h0001;
				end
				2'd1:
				begin
					v[16] = v[16] | (v[15:0] == 16'hFFFF);
					v[15:0] = v[15:0] + 16'h0001;
				end
				default:
				begin
					v[16] = v[16] | (v[7:0] == 8'hFF);
					v[7:0] = (v[7:0] == 8'hFF) ? v[15:8] : v[7:0] + 8'h01;
				end
			endcase
		return v;
	endfunction
	task automatic ev(input logic t, input logic [1:0] m, input logic [7:0] h,
		input logic [7:0] l, input int n);
		logic [16:0] e;
		logic [5:0]  lo;
		logic [2:0]  gpi;
		gpi = 3'($random(seed));
		lo = t ? timer_pkg::OFS_B_LOW : timer_pkg::OFS_A_LOW;
		e = model(m, h, l, (gpi[0] && gpi[1] != gpi[2]) ? 0 : n);
		wr(timer_pkg::OFS_CONTROL, 8'h00);
		wr(timer_pkg::OFS_EXTCFG, {6'h00, gpi[2], gpi[2]});
		wr(timer_pkg::OFS_IRQEN, {6'h00, gpi[1], gpi[1]});
		wr(timer_pkg::OFS_MODE, t ? {gpi[0], 1'b1, m, 4'h0} : {4'h0, gpi[0], 1'b1, m});
		wr(lo, l);
		wr(lo + 6'h04, h);
		i_far.set_gate(t, gpi[1]);
		wr(timer_pkg::OFS_CONTROL, t ? 8'h40 : 8'h10);
		i_far.pulse(t, n);
		repeat (4) @(posedge clk_sys);
		rd(lo);
		chk(rd_byte, e[7:0]);
		rd(lo + 6'h04);
		chk(rd_byte, e[15:8]);
		rd(timer_pkg::OFS_CONTROL);
		chk({7'h00, rd_byte[t ? 7 : 5]}, {7'h00, e[16]});
		chk({7'h00, irq_req[t]}, {7'h00, e[16] & gpi[1]});
		@(posedge clk_sys);
		irq_ack[t] <= 1'b1;
		@(posedge clk_sys);
		irq_ack[t] <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk({7'h00, irq_req[t]}, 8'h00);
	endtask
	initial
	begin
		seed = 81423;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		s_axi_wstrb = 4'hF;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		{irq_ack, err_total, check_count} = '0;
		rst = 1'b1;
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		for (k = 0; k < 10; k++)
		begin
			rd(6'(k * 4));
			chk(rd_byte, 8'h00);
			chk({6'h00, rd_resp}, (k == 9) ? 8'h02 : 8'h00);
		end
		wr(6'h24, 8'hFF);
		chk({6'h00, last_b}, 8'h02);
		wr(timer_pkg::OFS_CONTROL, 8'h0F);
		rd(timer_pkg::OFS_CONTROL);
		chk(rd_byte, 8'h00);
		ev(1'b0, 2'd0, 8'hFF, 8'hFF, 1);
		ev(1'b0, 2'd1, 8'hFF, 8'hFF, 1);
		ev(1'b1, 2'd2, 8'h7F, 8'hFE, 3);
		ev(1'b1, 2'd0, 8'hFF, 8'hFE, 3);
		repeat (12)
		begin
			r = $random(seed);
			ev(r[0], (r[2:1] == 2'b11) ? 2'b10 : r[2:1], r[3] ? 8'hFF : r[15:8], r[23:16],
				1 + r[29:24]);
		end
		for (k = 0; k < 5; k++)
		begin
			wr(timer_pkg::OFS_CONTROL, 8'h00);
			wr(timer_pkg::OFS_MODE, 8'h01);
			wr(timer_pkg::OFS_A_LOW, 8'h00);
			wr(timer_pkg::OFS_A_HIGH, 8'h00);
			wr(timer_pkg::OFS_CLKSEL, (k == 4) ? 8'h04 : 8'(k));
			wr(timer_pkg::OFS_CONTROL, 8'h10);
			t0 = cyc;
			repeat (1000) @(posedge clk_sys);
			wr(timer_pkg::OFS_CONTROL, 8'h00);
			exp_cnt = (cyc - t0) / div[k];
			rd(timer_pkg::OFS_A_LOW);
			cnt = rd_byte;
			rd(timer_pkg::OFS_A_HIGH);
			cnt = cnt + 256 * rd_byte;
			check_count++;
			if (cnt + 2 < exp_cnt || cnt > exp_cnt + 2)
			begin
				err_total++;
				$display("Error at %0t: count %0d expected %0d", $time, cnt, exp_cnt);
			end
		end
		wr(timer_pkg::OFS_CLKSEL, 8'h04);
		wr(timer_pkg::OFS_MODE, 8'h33);
		wr(timer_pkg::OFS_A_LOW, 8'h5A);
		wr(timer_pkg::OFS_A_HIGH, 8'hF0);
		wr(timer_pkg::OFS_B_LOW, 8'h11);
		wr(timer_pkg::OFS_CONTROL, 8'h40);
		repeat (40) @(posedge clk_sys);
		rd(timer_pkg::OFS_CONTROL);
		chk(rd_byte & 8'hA0, 8'h80);
		rd(timer_pkg::OFS_A_LOW);
		chk(rd_byte, 8'h5A);
		rd(timer_pkg::OFS_B_LOW);
		chk(rd_byte, 8'h11);
		wr(timer_pkg::OFS_CONTROL, 8'h00);
		wr(timer_pkg::OFS_CLKSEL, 8'h0C);
		wr(timer_pkg::OFS_B_HIGH, 8'hFF);
		wr(timer_pkg::OFS_B_LOW, 8'hF0);
		t0 = tick_n;
		wr(timer_pkg::OFS_MODE, 8'h13);
		repeat (40) @(posedge clk_sys);
		rd(timer_pkg::OFS_CONTROL);
		chk(rd_byte & 8'h80, 8'h00);
		rd(timer_pkg::OFS_B_HIGH);
		chk(rd_byte, 8'h00);
		chk(8'(tick_n - t0), 8'h01);
		complete_run();
	end
	initial
	begin
		repeat (50000) @(posedge clk_sys);
		err_total++;
		complete_run();
	end
endmodule

/* test/timer_asserts.sv */
`timescale 1ns/1ps
module timer_checker
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic [1:0]  s_axi_bresp,
	input  wire logic        s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	input  wire logic        s_axi_arready,
	input  wire logic [31:0] s_axi_rdata,
	input  wire logic [1:0]  s_axi_rresp,
	input  wire logic        s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        irq_req_a,
	input  wire logic        irq_req_b,
	input  wire logic        overflow_b_tick
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic wr_take;
	logic rd_take;
	assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
	assign rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	AST_WR_TAKE: assert property (wr_take |=> s_axi_awready && s_axi_wready ##1 !s_axi_awready)
		else $error("write not taken one cycle later");
	AST_WR_PAIR: assert property (s_axi_awready |-> s_axi_wready && s_axi_bvalid)
		else $error("write ready without response");
	AST_B_HOLD: assert property (s_axi_bvalid |=> $past(s_axi_bready) ? !s_axi_bvalid
		: s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_RD_TAKE: assert property (rd_take |=> s_axi_arready && s_axi_rvalid ##1 !s_axi_arready)
		else $error("read not taken one cycle later");
	AST_R_HOLD: assert property (s_axi_rvalid |=> $past(s_axi_rready) ? !s_axi_rvalid
		: s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_RD_HIGH: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits set");
	AST_WR_ERR: assert property (wr_take && s_axi_awaddr > 32'h00000020
		|=> s_axi_bresp == timer_pkg::RESP_SLVERR)
		else $error("unmapped write not refused");
	AST_RD_ERR: assert property (rd_take && (s_axi_araddr > 32'h00000020
		|| s_axi_araddr[1:0] != 2'h0)
		|=> s_axi_rresp == timer_pkg::RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
	cover property (irq_req_a);
	cover property (irq_req_b);
	cover property (overflow_b_tick);
endmodule
bind dual_legacy_counter_timer timer_checker i_chk (.clk_sys, .rst, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
	.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_req_a, .irq_req_b,
	.overflow_b_tick);

/* test/timer_far_side.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Event pins, gate levels, external clock
// ----------------------------------------
module timer_far_side
(
	input  wire logic clk_sys,
	output logic      event_pin_a,
	output logic      event_pin_b,
	output logic      gate_input_a,
	output logic      gate_input_b,
	output logic      ext_clk
);
	logic [1:0] ev;
	logic [1:0] gt;
	assign event_pin_a  = ev[0];
	assign event_pin_b  = ev[1];
	assign gate_input_a = gt[0];
	assign gate_input_b = gt[1];
	initial
	begin
		ev = 2'h3;
		gt = 2'h0;
		ext_clk = 1'b0;
		#3;
		forever #25 ext_clk = ~ext_clk;
	end
	// Two cycles low, two high: fastest legal event rate
	task automatic pulse(input logic t, input int n);
		repeat (n)
		begin
			@(posedge clk_sys);
			ev[t] <= 1'b0;
			repeat (2) @(posedge clk_sys);
			ev[t] <= 1'b1;
			@(posedge clk_sys);
		end
	endtask
	task automatic set_gate(input logic t, input logic v);
		@(posedge clk_sys);
		gt[t] <= v;
	endtask
endmodule
